/* dem_pkg.sv */
`default_nettype none
package dem_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int DEM_AW   = 12;
	localparam int DEM_DW   = 32;
	localparam int DEM_M0_W = 21;
	localparam int DEM_M1_W = 13;
	localparam int DEM_ACK_W = 16;
	localparam int DEM_PHY_W = 5;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [DEM_AW-1:0] DEM_OFS_ST0 = 12'h0bc;
	localparam logic [DEM_AW-1:0] DEM_OFS_ST1 = 12'h0c0;
	localparam logic [DEM_AW-1:0] DEM_OFS_M0  = 12'h0c4;
	localparam logic [DEM_AW-1:0] DEM_OFS_M1  = 12'h0c8;

	// ------------------------------------------------------------
	// Field positions, first status and mask
	// ------------------------------------------------------------
	localparam int DEM_F0_ACK_LSB = 0;
	localparam int DEM_F0_PHY_LSB = 16;

	// ------------------------------------------------------------
	// Field positions, second status and mask
	// ------------------------------------------------------------
	localparam int DEM_F1_HS_TO    = 0;
	localparam int DEM_F1_LP_TO    = 1;
	localparam int DEM_F1_ECC_ONE  = 2;
	localparam int DEM_F1_ECC_MULT = 3;
	localparam int DEM_F1_CRC      = 4;
	localparam int DEM_F1_PKT_SIZE = 5;
	localparam int DEM_F1_EOTP     = 6;
	localparam int DEM_F1_DPI_FULL = 7;
	localparam int DEM_F1_CMD_WR   = 8;
	localparam int DEM_F1_PLD_WR   = 9;
	localparam int DEM_F1_PLD_SEND = 10;
	localparam int DEM_F1_PLD_RD   = 11;
	localparam int DEM_F1_PLD_RECV = 12;

	// ------------------------------------------------------------
	// State and reset values
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DEM_M0_W-1:0] mask0;
		logic [DEM_M1_W-1:0] mask1;
		logic [DEM_M0_W-1:0] st0;
		logic [DEM_M1_W-1:0] st1;
		logic [DEM_DW-1:0]   rdata;
		logic                irq;
		logic                cmd_push;
		logic                pld_push;
	} dem_state_t;

	localparam logic [DEM_M0_W-1:0] DEM_M0_RST = 21'h0;
	localparam logic [DEM_M1_W-1:0] DEM_M1_RST = 13'h0;
	localparam dem_state_t DEM_STATE_RST = '{
		mask0: DEM_M0_RST, mask1: DEM_M1_RST, st0: 21'h0, st1: 13'h0,
		rdata: 32'h0, irq: 1'b0, cmd_push: 1'b0, pld_push: 1'b0};

endpackage : dem_pkg
`default_nettype wire

/* dem_top.sv */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - First mask register at 0x0c4 gates each first status source.
// - First mask bits 20..16 gate lane 0 PHY errors.
// - First mask bits 15..0 gate acknowledge report bits position for position.
// - Acknowledge bits: SoT, syncs, escape, timeouts, ECC, checksum, type, channel, length, protocol.
// - Second mask at 0x0c8 gates second status; bits 31..13 read zero.
// - Command write into full command FIFO is dropped, flags bit 8.
// - Payload write into full payload FIFO is discarded, flags bit 9.
// - Payload FIFO empty while building generic packet flags bit 10.
// - Payload FIFO empty while delivering read data flags bit 11.
// - Payload FIFO full during generic read back flags bit 12.
// - Pixel FIFO full while storing video line flags bit 7.
// - Peripheral transmission ending without end-of-transmission packet flags bit 6.
// - Packet size error during reception flags bit 5.
// - Received packet failing CRC flags bit 4.
// - Multi-bit header ECC error flags bit 3.
// - Corrected single-bit header ECC error flags bit 2.
// - Low-power receive timeout with contention flags bit 1.
// - High-speed transmit timeout with contention flags bit 0.
module dem_top (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic [dem_pkg::DEM_AW-1:0]    addr,
	input  wire logic [dem_pkg::DEM_DW-1:0]    wdata,
	input  wire logic                          wr_en,
	input  wire logic                          rd_en,
	output logic      [dem_pkg::DEM_DW-1:0]    rdata,
	input  wire logic [dem_pkg::DEM_PHY_W-1:0] phy_err_evt,
	input  wire logic                          ack_report_vld,
	input  wire logic [dem_pkg::DEM_ACK_W-1:0] ack_report,
	input  wire logic                          gen_cmd_wr,
	input  wire logic                          cmd_fifo_full,
	input  wire logic                          gen_pld_wr,
	input  wire logic                          pld_wr_fifo_full,
	input  wire logic                          gen_pkt_build,
	input  wire logic                          pld_wr_fifo_empty,
	input  wire logic                          dcs_rd_deliver,
	input  wire logic                          pld_rd_fifo_empty,
	input  wire logic                          gen_rd_back,
	input  wire logic                          pld_rd_fifo_full,
	input  wire logic                          dpi_line_store,
	input  wire logic                          pixel_fifo_full,
	input  wire logic                          rx_trans_end,
	input  wire logic                          rx_eotp_seen,
	input  wire logic                          rx_pkt_size_err,
	input  wire logic                          rx_crc_err,
	input  wire logic                          rx_ecc_multi,
	input  wire logic                          rx_ecc_single_fix,
	input  wire logic                          lp_receive_timeout,
	input  wire logic                          lp_contention,
	input  wire logic                          hs_transmit_timeout,
	input  wire logic                          hs_contention,
	output logic                               cmd_fifo_push,
	output logic                               pld_fifo_push,
	output logic                               irq
);
	import dem_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	dem_state_t           s_r;
	dem_state_t           s_nxt;
	logic                 sel_st0;
	logic                 sel_st1;
	logic                 sel_m0;
	logic                 sel_m1;
	logic [DEM_M0_W-1:0]  set0;
	logic [DEM_M1_W-1:0]  set1;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	always_comb begin
		sel_st0 = 1'b0;
		sel_st1 = 1'b0;
		sel_m0  = 1'b0;
		sel_m1  = 1'b0;
		if (addr == DEM_OFS_ST0) begin
			sel_st0 = 1'b1;
		end else if (addr == DEM_OFS_ST1) begin
			sel_st1 = 1'b1;
		end else if (addr == DEM_OFS_M0) begin
			sel_m0 = 1'b1;
		end else if (addr == DEM_OFS_M1) begin
			sel_m1 = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Event sources
	// ------------------------------------------------------------
	// First status: PHY lane 0 pulses above the acknowledge report
	always_comb begin
		set0 = '0;
		set0[DEM_F0_PHY_LSB +: DEM_PHY_W] = phy_err_evt;
		if (ack_report_vld) begin
			set0[DEM_F0_ACK_LSB +: DEM_ACK_W] = ack_report;
		end
	end

	// Second status: each flag except bits 5..2 is a qualified condition
	always_comb begin
		set1 = '0;
		set1[DEM_F1_CMD_WR]   = gen_cmd_wr & cmd_fifo_full;
		set1[DEM_F1_PLD_WR]   = gen_pld_wr & pld_wr_fifo_full;
		set1[DEM_F1_PLD_SEND] = gen_pkt_build & pld_wr_fifo_empty;
		set1[DEM_F1_PLD_RD]   = dcs_rd_deliver & pld_rd_fifo_empty;
		set1[DEM_F1_PLD_RECV] = gen_rd_back & pld_rd_fifo_full;
		set1[DEM_F1_DPI_FULL] = dpi_line_store & pixel_fifo_full;
		set1[DEM_F1_EOTP]     = rx_trans_end & ~rx_eotp_seen;
		set1[DEM_F1_PKT_SIZE] = rx_pkt_size_err;
		set1[DEM_F1_CRC]      = rx_crc_err;
		set1[DEM_F1_ECC_MULT] = rx_ecc_multi;
		set1[DEM_F1_ECC_ONE]  = rx_ecc_single_fix;
		set1[DEM_F1_LP_TO]    = lp_receive_timeout & lp_contention;
		set1[DEM_F1_HS_TO]    = hs_transmit_timeout & hs_contention;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Status clears on read, but a new event in that cycle wins
	always_comb begin
		s_nxt = s_r;
		s_nxt.st0 = ((rd_en && sel_st0) ? '0 : s_r.st0) | set0;
		s_nxt.st1 = ((rd_en && sel_st1) ? '0 : s_r.st1) | set1;
		// Only implemented bits are stored, so reserved writes vanish
		if (wr_en && sel_m0) begin
			s_nxt.mask0 = wdata[DEM_M0_W-1:0];
		end
		if (wr_en && sel_m1) begin
			s_nxt.mask1 = wdata[DEM_M1_W-1:0];
		end
		// Read data stands one cycle only, zero elsewhere
		s_nxt.rdata = '0;
		if (rd_en) begin
			if (sel_st0) begin
				s_nxt.rdata = {{(DEM_DW-DEM_M0_W){1'b0}}, s_r.st0};
			end else if (sel_st1) begin
				s_nxt.rdata = {{(DEM_DW-DEM_M1_W){1'b0}}, s_r.st1};
			end else if (sel_m0) begin
				s_nxt.rdata = {{(DEM_DW-DEM_M0_W){1'b0}}, s_r.mask0};
			end else if (sel_m1) begin
				s_nxt.rdata = {{(DEM_DW-DEM_M1_W){1'b0}}, s_r.mask1};
			end
		end
		// Full FIFO: the push is withheld, the write is lost
		s_nxt.cmd_push = gen_cmd_wr & ~cmd_fifo_full;
		s_nxt.pld_push = gen_pld_wr & ~pld_wr_fifo_full;
		// Built from next values so irq tracks the stored status exactly
		s_nxt.irq = (|(s_nxt.st0 & s_nxt.mask0)) | (|(s_nxt.st1 & s_nxt.mask1));
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= DEM_STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flops
	assign rdata         = s_r.rdata;
	assign irq           = s_r.irq;
	assign cmd_fifo_push = s_r.cmd_push;
	assign pld_fifo_push = s_r.pld_push;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_mask0_wr;
		@(posedge clk) disable iff (!nrst)
		(wr_en && addr == DEM_OFS_M0) |=> (s_r.mask0 == $past(wdata[DEM_M0_W-1:0]));
	endproperty
	a_mask0_wr: assert property (p_mask0_wr) else $error("first mask not written");

	property p_mask1_rd;
		@(posedge clk) disable iff (!nrst)
		(rd_en && addr == DEM_OFS_M1 && !wr_en)
			|=> (rdata[DEM_DW-1:DEM_M1_W] == '0) && (rdata[DEM_M1_W-1:0] == $past(s_r.mask1));
	endproperty
	a_mask1_rd: assert property (p_mask1_rd) else $error("second mask readback wrong");

	// Upper bits must read zero whatever was written there
	property p_mask0_rd;
		@(posedge clk) disable iff (!nrst)
		(rd_en && addr == DEM_OFS_M0 && !wr_en)
			|=> (rdata[DEM_DW-1:DEM_M0_W] == '0) && (rdata[DEM_M0_W-1:0] == $past(s_r.mask0));
	endproperty
	a_mask0_rd: assert property (p_mask0_rd) else $error("first mask readback wrong");

	// A read with no new event leaves the first status empty
	property p_st0_clear;
		@(posedge clk) disable iff (!nrst)
		(rd_en && addr == DEM_OFS_ST0 && !ack_report_vld && phy_err_evt == '0)
			|=> (s_r.st0 == '0);
	endproperty
	a_st0_clear: assert property (p_st0_clear) else $error("first status not cleared by read");

	// Clear and set in one cycle: only the new events survive
	property p_clr_set;
		@(posedge clk) disable iff (!nrst)
		(rd_en && addr == DEM_OFS_ST1) |=> (s_r.st1 == $past(set1));
	endproperty
	a_clr_set: assert property (p_clr_set) else $error("second status clear lost a new event");

	// ------------------------------------------------------------
	// Event assertions
	// ------------------------------------------------------------

	property p_ack_set;
		@(posedge clk) disable iff (!nrst)
		ack_report_vld |=> ((s_r.st0[DEM_ACK_W-1:0] & $past(ack_report)) == $past(ack_report));
	endproperty
	a_ack_set: assert property (p_ack_set) else $error("ack report bit lost");

	// Lane pulses land in the upper field of the first status
	property p_phy_set;
		@(posedge clk) disable iff (!nrst)
		(phy_err_evt != '0)
			|=> ((s_r.st0[DEM_F0_PHY_LSB +: DEM_PHY_W] & $past(phy_err_evt)) == $past(phy_err_evt));
	endproperty
	a_phy_set: assert property (p_phy_set) else $error("phy lane error bit lost");

	property p_cmd_drop;
		@(posedge clk) disable iff (!nrst)
		(gen_cmd_wr && cmd_fifo_full) |=> (s_r.st1[DEM_F1_CMD_WR] && !cmd_fifo_push);
	endproperty
	a_cmd_drop: assert property (p_cmd_drop) else $error("full command write not dropped");

	property p_pld_drop;
		@(posedge clk) disable iff (!nrst)
		(gen_pld_wr && pld_wr_fifo_full) |=> (s_r.st1[DEM_F1_PLD_WR] && !pld_fifo_push);
	endproperty
	a_pld_drop: assert property (p_pld_drop) else $error("full payload write not dropped");

	property p_cmd_push;
		@(posedge clk) disable iff (!nrst)
		(gen_cmd_wr && !cmd_fifo_full) |=> cmd_fifo_push;
	endproperty
	a_cmd_push: assert property (p_cmd_push) else $error("command write not pushed");

	property p_pld_push;
		@(posedge clk) disable iff (!nrst)
		(gen_pld_wr && !pld_wr_fifo_full) |=> pld_fifo_push;
	endproperty
	a_pld_push: assert property (p_pld_push) else $error("payload write not pushed");

	property p_send_empty;
		@(posedge clk) disable iff (!nrst)
		(gen_pkt_build && pld_wr_fifo_empty) |=> s_r.st1[DEM_F1_PLD_SEND];
	endproperty
	a_send_empty: assert property (p_send_empty) else $error("payload empty on build not flagged");

	property p_rd_empty;
		@(posedge clk) disable iff (!nrst)
		(dcs_rd_deliver && pld_rd_fifo_empty) |=> s_r.st1[DEM_F1_PLD_RD];
	endproperty
	a_rd_empty: assert property (p_rd_empty) else $error("payload empty on delivery not flagged");

	property p_full_flags;
		@(posedge clk) disable iff (!nrst)
		(gen_rd_back && pld_rd_fifo_full) |=> s_r.st1[DEM_F1_PLD_RECV];
	endproperty
	a_full_flags: assert property (p_full_flags) else $error("read back full not flagged");

	property p_dpi_full;
		@(posedge clk) disable iff (!nrst)
		(dpi_line_store && pixel_fifo_full) |=> s_r.st1[DEM_F1_DPI_FULL];
	endproperty
	a_dpi_full: assert property (p_dpi_full) else $error("pixel fifo full not flagged");

	property p_eotp;
		@(posedge clk) disable iff (!nrst)
		(rx_trans_end && !rx_eotp_seen) |=> s_r.st1[DEM_F1_EOTP];
	endproperty
	a_eotp: assert property (p_eotp) else $error("missing eotp not flagged");

	property p_size_err;
		@(posedge clk) disable iff (!nrst)
		rx_pkt_size_err |=> s_r.st1[DEM_F1_PKT_SIZE];
	endproperty
	a_size_err: assert property (p_size_err) else $error("packet size error not flagged");

	property p_crc_err;
		@(posedge clk) disable iff (!nrst)
		rx_crc_err |=> s_r.st1[DEM_F1_CRC];
	endproperty
	a_crc_err: assert property (p_crc_err) else $error("crc error not flagged");

	property p_ecc_multi;
		@(posedge clk) disable iff (!nrst)
		rx_ecc_multi |=> s_r.st1[DEM_F1_ECC_MULT];
	endproperty
	a_ecc_multi: assert property (p_ecc_multi) else $error("multi-bit ecc error not flagged");

	property p_ecc_single;
		@(posedge clk) disable iff (!nrst)
		rx_ecc_single_fix |=> s_r.st1[DEM_F1_ECC_ONE];
	endproperty
	a_ecc_single: assert property (p_ecc_single) else $error("single-bit ecc error not flagged");

	property p_timeout;
		@(posedge clk) disable iff (!nrst)
		(hs_transmit_timeout && !hs_contention && !s_r.st1[DEM_F1_HS_TO]) |=> !s_r.st1[DEM_F1_HS_TO];
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout flagged without contention");

	property p_lp_timeout;
		@(posedge clk) disable iff (!nrst)
		(lp_receive_timeout && lp_contention) |=> s_r.st1[DEM_F1_LP_TO];
	endproperty
	a_lp_timeout: assert property (p_lp_timeout) else $error("receive timeout not flagged");

	property p_hs_timeout;
		@(posedge clk) disable iff (!nrst)
		(hs_transmit_timeout && hs_contention) |=> s_r.st1[DEM_F1_HS_TO];
	endproperty
	a_hs_timeout: assert property (p_hs_timeout) else $error("transmit timeout not flagged");

	// ------------------------------------------------------------
	// Interrupt and read data
	// ------------------------------------------------------------
	property p_irq;
		@(posedge clk) disable iff (!nrst)
		irq == ((|(s_r.st0 & s_r.mask0)) || (|(s_r.st1 & s_r.mask1)));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt disagrees with masked status");

	property p_rdata_idle;
		@(posedge clk) disable iff (!nrst)
		!rd_en |=> (rdata == '0);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

	// ------------------------------------------------------------
	// Coverage
	// ------------------------------------------------------------
	c_irq_rise: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));
	c_cmd_drop: cover property (@(posedge clk) disable iff (!nrst) gen_cmd_wr && cmd_fifo_full);
	c_clr_set:  cover property (@(posedge clk) disable iff (!nrst)
		rd_en && addr == DEM_OFS_ST1 && (|set1));
	c_phy_err:  cover property (@(posedge clk) disable iff (!nrst) ##1 s_r.st0[DEM_F0_PHY_LSB]);

endmodule : dem_top
`default_nettype wire

/* dem_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Host software stand-in: plain register bus master
module dem_host (
	input  wire logic                       clk,
	output var  logic [dem_pkg::DEM_AW-1:0] addr,
	output var  logic [dem_pkg::DEM_DW-1:0] wdata,
	output var  logic                       wr_en,
	output var  logic                       rd_en,
	input  wire logic [dem_pkg::DEM_DW-1:0] rdata
);
	import dem_pkg::*;
	// Idle bus at time zero
	initial begin
		addr  = '0;
		wdata = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end
	// One-cycle write strobe; data inverted after release so stale data never looks valid
	task automatic wr(input logic [DEM_AW-1:0] a, input logic [DEM_DW-1:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		wdata <= ~d;
	endtask : wr
	// Read data taken only in the cycle after the strobe
	task automatic rd(input logic [DEM_AW-1:0] a, output logic [DEM_DW-1:0] d);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask : rd
endmodule : dem_host
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
	import dem_pkg::*;
	logic clk, nrst, wr_en, rd_en, irq, cmd_push, pld_push;
	logic [DEM_AW-1:0] addr;
	logic [DEM_DW-1:0] wdata, rdata, d, m, a, p;
	logic [22:0]       ev;
	logic [4:0]        phy;
	logic [15:0]       ack;
	int bad_count, compares, seed;
	// Event bits: one source per bit, status bit k raised by PAT[k]; last five must not flag
	logic [22:0] pat [0:17] = '{23'h3, 23'hc, 23'h10, 23'h20, 23'h40, 23'h80, 23'h100, 23'hc00,
		23'h3000, 23'hc000, 23'h30000, 23'hc0000, 23'h300000, 23'h300, 23'h1, 23'h1000, 23'h10000, 23'h4000};
	logic [DEM_AW-1:0] ofs [0:4] = '{DEM_OFS_M0, DEM_OFS_M1, DEM_OFS_ST0, DEM_OFS_ST1, 12'h0cc};

	dem_host dem_host_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
	dem_top dem_top_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .phy_err_evt(phy), .ack_report_vld(ev[22]), .ack_report(ack),
		.gen_cmd_wr(ev[12]), .cmd_fifo_full(ev[13]), .gen_pld_wr(ev[14]), .pld_wr_fifo_full(ev[15]),
		.gen_pkt_build(ev[16]), .pld_wr_fifo_empty(ev[17]), .dcs_rd_deliver(ev[18]),
		.pld_rd_fifo_empty(ev[19]), .gen_rd_back(ev[20]), .pld_rd_fifo_full(ev[21]),
		.dpi_line_store(ev[10]), .pixel_fifo_full(ev[11]), .rx_trans_end(ev[8]), .rx_eotp_seen(ev[9]),
		.rx_pkt_size_err(ev[7]), .rx_crc_err(ev[6]), .rx_ecc_multi(ev[5]), .rx_ecc_single_fix(ev[4]),
		.lp_receive_timeout(ev[2]), .lp_contention(ev[3]), .hs_transmit_timeout(ev[0]),
		.hs_contention(ev[1]), .cmd_fifo_push(cmd_push), .pld_fifo_push(pld_push), .irq(irq));

	// ----------------------------------------------------------
	// Clock, closing and watchdog
	// ----------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic print_verdict;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	// Whole run is a few hundred cycles; this is ample margin
	initial begin
		#50us;
		bad_count++;
		print_verdict();
	end

	// ----------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------
	// One-cycle event, then look at the registered outputs it caused
	task automatic fire(input logic [22:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev  <= '0;
		phy <= '0;
		ack <= '0;
		@(posedge clk);
	endtask : fire

	// Main sequence with the expected values kept in plain integers
	initial begin
		nrst = 1'b0;
		ev = '0;
		phy = '0;
		ack = '0;
		seed = 32'h0d9d;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		// Everything reads zero after reset, unmapped place included
		for (int i = 0; i < 5; i++) begin
			dem_host_inst.rd(ofs[i], d);
			`CHK(d, 32'h0)
		end
		`CHK(irq, 1'b0)
		// Reserved bits ignore writes; unmapped writes go nowhere
		dem_host_inst.wr(DEM_OFS_M0, 32'hffffffff);
		dem_host_inst.rd(DEM_OFS_M0, d);
		`CHK(d, 32'h001fffff)
		dem_host_inst.wr(DEM_OFS_M1, 32'hffffffff);
		dem_host_inst.rd(DEM_OFS_M1, d);
		`CHK(d, 32'h00001fff)
		dem_host_inst.wr(12'h0cc, 32'hffffffff);
		dem_host_inst.rd(12'h0cc, d);
		`CHK(d, 32'h0)
		// Second status sources, all enabled then a random mask
		for (int q = 0; q < 2; q++) begin
			m = q ? ($random(seed) & 32'h1fff) : 32'h1fff;
			dem_host_inst.wr(DEM_OFS_M1, m);
			for (int k = 0; k < 18; k++) begin
				fire(pat[k]);
				a = (k < 13) ? (32'h1 << k) : 32'h0;
				`CHK(irq, |(a & m))
				`CHK(cmd_push, pat[k][12] & ~pat[k][13])
				`CHK(pld_push, pat[k][14] & ~pat[k][15])
				dem_host_inst.rd(DEM_OFS_ST1, d);
				`CHK(d, a)
			end
		end
		// Event in the very cycle its status is read: the set wins
		fork
			dem_host_inst.rd(DEM_OFS_ST1, d);
			fire(pat[4]);
		join
		`CHK(d, 32'h0)
		`CHK(irq, m[DEM_F1_CRC])
		dem_host_inst.rd(DEM_OFS_ST1, d);
		`CHK(d, 32'h10)
		// First status: PHY lane errors above the acknowledge report
		for (int q = 0; q < 4; q++) begin
			m = $random(seed) & 32'h1fffff;
			dem_host_inst.wr(DEM_OFS_M0, m);
			p = $random(seed);
			a = $random(seed);
			phy <= p[4:0];
			ack <= a[15:0];
			fire(23'h400000);
			a = {11'h0, p[4:0], a[15:0]};
			`CHK(irq, |(a & m))
			dem_host_inst.rd(DEM_OFS_ST0, d);
			`CHK(d, a)
			dem_host_inst.rd(DEM_OFS_ST0, d);
			`CHK(d, 32'h0)
			`CHK(irq, 1'b0)
		end
		// Mid-run reset must bring both masks back to zero
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		dem_host_inst.rd(DEM_OFS_M0, d);
		`CHK(d, 32'h0)
		dem_host_inst.rd(DEM_OFS_M1, d);
		`CHK(d, 32'h0)
		print_verdict();
	end
endmodule : tb_top
`undef CHK
`default_nettype wire
